// *** mpc_pkg.sv ***
// Purpose: shared constants and types for the message-passing capability bank
// Assumes: byte offsets of the 24-bit configuration space, big-endian bit numbers
// Notes:   one clock, synchronous active-high reset
package mpc_pkg;

  // configuration space layout, byte offsets
  localparam logic [23:0] OFS_SRC_CAP      = 24'h000018;
  localparam logic [23:0] OFS_DST_CAP      = 24'h00001C;
  localparam logic [23:0] CAR_SPACE_LAST   = 24'h00003C;
  localparam logic [23:0] CSR_SPACE_BASE   = 24'h000040;
  localparam logic [23:0] EXT_SPACE_BASE   = 24'h000100;
  localparam logic [23:0] IMPL_SPACE_BASE  = 24'h010000;
  localparam logic [23:0] OFS_IMPL_SCRATCH = 24'h010000;
  localparam logic [23:0] OFS_IMPL_RD_CNT  = 24'h010004;
  localparam logic [23:0] OFS_IMPL_WR_CNT  = 24'h010008;
  localparam logic [23:0] OFS_IMPL_FWD_CNT = 24'h01000C;

  // capability fields, big-endian bit numbers (0 = msb)
  localparam int BIT_IMPL_A_HI = 14;
  localparam int BIT_IMPL_A_LO = 15;
  localparam int BIT_DATA_MSG  = 20;
  localparam int BIT_DOORBELL  = 21;
  localparam int BIT_IMPL_B_HI = 30;
  localparam int BIT_IMPL_B_LO = 31;
  localparam int WORD_MSB      = 31;

  // reset values
  localparam logic [31:0] SCRATCH_RST = 32'h00000000;
  localparam logic [31:0] CNT_RST     = 32'h00000000;
  localparam logic [31:0] ZERO_WORD   = 32'h00000000;

  // response status codes
  localparam logic [3:0] STAT_DONE  = 4'h0;
  localparam logic [3:0] STAT_ERROR = 4'h7;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } mpc_state_t;

  typedef struct packed
  {
    logic        write;
    logic        dword;
    logic [23:0] offset;
    logic [63:0] wdata;
  } mpc_req_t;

  typedef struct packed
  {
    logic        write;
    logic [3:0]  status;
    logic [63:0] rdata;
  } mpc_rsp_t;

  typedef struct packed
  {
    logic [3:0]  ftype;
    logic        last;
    logic [31:0] data;
  } mpc_pkt_t;

  typedef struct packed
  {
    logic       data_msg;
    logic       doorbell;
    logic [1:0] impl_a;
    logic [1:0] impl_b;
  } mpc_cap_t;

endpackage

// *** mpc_cap_word.sv ***
// Purpose: builds one 32-bit capability word from its field settings
// Assumes: field settings are design-time constants
// Notes:   big-endian numbering, bit n lands on vector bit 31-n
`timescale 1ns/1ps
module mpc_cap_word
  import mpc_pkg::*;
(
  input  mpc_cap_t    cap,
  output logic [31:0] word
);

  function automatic int be_pos(input int n);
    be_pos = WORD_MSB - n;
  endfunction

  // reserved bits stay zero
  always_comb
  begin
    word                        = ZERO_WORD;
    word[be_pos(BIT_IMPL_A_HI)] = cap.impl_a[1];
    word[be_pos(BIT_IMPL_A_LO)] = cap.impl_a[0];
    word[be_pos(BIT_DATA_MSG)]  = cap.data_msg;
    word[be_pos(BIT_DOORBELL)]  = cap.doorbell;
    word[be_pos(BIT_IMPL_B_HI)] = cap.impl_b[1];
    word[be_pos(BIT_IMPL_B_LO)] = cap.impl_b[0];
  end

endmodule

// *** mpc_fwd.sv ***
// Purpose: one-stage packet pass-through for the switch path
// Assumes: valid/ready handshake on both sides
// Notes:   every format type passes, supported locally or not
`timescale 1ns/1ps
module mpc_fwd
  import mpc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic in_valid,
  output logic      in_ready,
  input  mpc_pkt_t  in_pkt,
  output logic      out_valid,
  input  wire logic out_ready,
  output mpc_pkt_t  out_pkt,
  output logic      taken
);

  logic     valid_reg;
  mpc_pkt_t pkt_reg;

  // stall reaches the source through in_ready
  assign in_ready  = ce && (!valid_reg || out_ready);
  assign taken     = in_valid && in_ready;
  assign out_valid = valid_reg;
  assign out_pkt   = pkt_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      valid_reg <= 1'b0;
      pkt_reg   <= '0;
    end
    else if (ce)
    begin
      if (taken)
      begin
        valid_reg <= 1'b1;
        pkt_reg   <= in_pkt;
      end
      else if (out_ready)
      begin
        valid_reg <= 1'b0;
      end
    end
  end

endmodule

// *** mpc_regs.sv ***
// Purpose: capability register bank answering maintenance reads and writes
// Assumes: requester is logic on the same clock; one request outstanding
// Notes:   every access completes with DONE status, none ever errors
`timescale 1ns/1ps

module mpc_regs
  import mpc_pkg::*;
#(
  parameter mpc_cap_t SRC_CAP = '{data_msg: 1'b1, doorbell: 1'b1, impl_a: 2'b00, impl_b: 2'b00},
  parameter mpc_cap_t DST_CAP = '{data_msg: 1'b1, doorbell: 1'b1, impl_a: 2'b00, impl_b: 2'b00}
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic req_valid,
  output logic      req_ready,
  input  mpc_req_t  req,
  output logic      rsp_valid,
  input  wire logic rsp_ready,
  output mpc_rsp_t  rsp,
  input  wire logic fwd_in_valid,
  output logic      fwd_in_ready,
  input  mpc_pkt_t  fwd_in,
  output logic      fwd_out_valid,
  input  wire logic fwd_out_ready,
  output mpc_pkt_t  fwd_out,
  output logic      busy
);

  mpc_state_t  state_reg;
  mpc_state_t  state_next;
  mpc_rsp_t    rsp_reg;
  mpc_rsp_t    rsp_next;
  logic [31:0] scratch_reg;
  logic [31:0] scratch_next;
  logic [31:0] rd_cnt_reg;
  logic [31:0] rd_cnt_next;
  logic [31:0] wr_cnt_reg;
  logic [31:0] wr_cnt_next;
  logic [31:0] fwd_cnt_reg;
  logic [31:0] fwd_cnt_next;

  logic [31:0] src_word;
  logic [31:0] dst_word;
  logic        accept;
  logic        is_rd;
  logic        is_wr;
  logic        fwd_taken;
  logic [23:0] word_ofs;
  logic [23:0] hi_ofs;
  logic [23:0] lo_ofs;
  logic [31:0] hi_word;
  logic [31:0] lo_word;
  logic [63:0] rd_data;
  logic        wr_scratch;
  logic        wr_rd_cnt;
  logic        wr_wr_cnt;
  logic        wr_fwd_cnt;
  logic        in_impl;

  // capability words come from parameters only, so every read matches
  mpc_cap_word u_src_cap
  (
    .cap  (SRC_CAP),
    .word (src_word)
  );

  mpc_cap_word u_dst_cap
  (
    .cap  (DST_CAP),
    .word (dst_word)
  );

  mpc_fwd u_fwd
  (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (fwd_in_valid),
    .in_ready  (fwd_in_ready),
    .in_pkt    (fwd_in),
    .out_valid (fwd_out_valid),
    .out_ready (fwd_out_ready),
    .out_pkt   (fwd_out),
    .taken     (fwd_taken)
  );

  // low two offset bits ignored: registers sit on word boundaries
  // registers come in as arguments, not from module scope, so the
  // continuous assignments re-evaluate whenever a register moves
  function automatic logic [31:0] read_word
  (
    input logic [23:0] ofs,
    input logic [31:0] src,
    input logic [31:0] dst,
    input logic [31:0] scr,
    input logic [31:0] rdc,
    input logic [31:0] wrc,
    input logic [31:0] fwc
  );
    logic [23:0] w;
    w = {ofs[23:2], 2'b00};
    case (w)
      OFS_SRC_CAP:      read_word = src;
      OFS_DST_CAP:      read_word = dst;
      OFS_IMPL_SCRATCH: read_word = scr;
      OFS_IMPL_RD_CNT:  read_word = rdc;
      OFS_IMPL_WR_CNT:  read_word = wrc;
      OFS_IMPL_FWD_CNT: read_word = fwc;
      default:          read_word = ZERO_WORD;
    endcase
  endfunction

  function automatic logic is_reg(input logic [23:0] ofs, input logic [23:0] target);
    is_reg = ({ofs[23:2], 2'b00} == target);
  endfunction

  // request side handshake
  assign req_ready = ce && (state_reg == ST_IDLE);
  assign accept    = req_valid && req_ready;
  assign is_rd     = accept && !req.write;
  assign is_wr     = accept && req.write;
  assign busy      = (state_reg != ST_IDLE);

  // double-word access reads the aligned pair, lower address in upper half
  assign word_ofs = {req.offset[23:2], 2'b00};
  assign hi_ofs   = req.dword ? {req.offset[23:3], 3'b000} : word_ofs;
  assign lo_ofs   = {req.offset[23:3], 3'b100};
  assign hi_word  = read_word(hi_ofs, src_word, dst_word, scratch_reg, rd_cnt_reg, wr_cnt_reg, fwd_cnt_reg);
  assign lo_word  = read_word(lo_ofs, src_word, dst_word, scratch_reg, rd_cnt_reg, wr_cnt_reg, fwd_cnt_reg);
  assign rd_data  = req.dword ? {hi_word, lo_word} : {ZERO_WORD, hi_word};

  // only implementation space takes writes; capability, status and
  // extended spaces swallow them, though each is still counted in wr_cnt_reg
  assign in_impl    = (req.offset >= IMPL_SPACE_BASE);
  assign wr_scratch = is_wr && in_impl && is_reg(req.offset, OFS_IMPL_SCRATCH);
  assign wr_rd_cnt  = is_wr && in_impl && is_reg(req.offset, OFS_IMPL_RD_CNT);
  assign wr_wr_cnt  = is_wr && in_impl && is_reg(req.offset, OFS_IMPL_WR_CNT);
  assign wr_fwd_cnt = is_wr && in_impl && is_reg(req.offset, OFS_IMPL_FWD_CNT);

  assign rsp_valid = (state_reg == ST_RESP);
  assign rsp       = rsp_reg;

  // response sequencing
  always_comb
  begin
    state_next = state_reg;
    rsp_next   = rsp_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_next      = ST_RESP;
          rsp_next.write  = req.write;
          rsp_next.status = STAT_DONE;
          rsp_next.rdata  = req.write ? 64'h0000000000000000 : rd_data;
        end
      end
      ST_RESP:
      begin
        if (rsp_ready)
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // implementation-defined scratch, written whole word
  always_comb
  begin
    scratch_next = scratch_reg;
    if (wr_scratch)
    begin
      scratch_next = req.dword ? req.wdata[63:32] : req.wdata[31:0];
    end
  end

  // counters clear on write; a same-cycle event is counted after the clear, leaving 1
  always_comb
  begin
    rd_cnt_next = wr_rd_cnt ? CNT_RST : rd_cnt_reg;
    if (is_rd)
    begin
      rd_cnt_next = rd_cnt_next + 32'h00000001;
    end
  end

  always_comb
  begin
    wr_cnt_next = wr_wr_cnt ? CNT_RST : wr_cnt_reg;
    if (is_wr)
    begin
      wr_cnt_next = wr_cnt_next + 32'h00000001;
    end
  end

  always_comb
  begin
    fwd_cnt_next = wr_fwd_cnt ? CNT_RST : fwd_cnt_reg;
    if (fwd_taken)
    begin
      fwd_cnt_next = fwd_cnt_next + 32'h00000001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      rsp_reg   <= '0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      rsp_reg   <= rsp_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scratch_reg <= SCRATCH_RST;
      rd_cnt_reg  <= CNT_RST;
      wr_cnt_reg  <= CNT_RST;
      fwd_cnt_reg <= CNT_RST;
    end
    else if (ce)
    begin
      scratch_reg <= scratch_next;
      rd_cnt_reg  <= rd_cnt_next;
      wr_cnt_reg  <= wr_cnt_next;
      fwd_cnt_reg <= fwd_cnt_next;
    end
  end

endmodule

// *** mpc_regs_monitor.sv ***
// Purpose: port checker for the capability bank
// Assumes: one clock, rst sync active high
// Notes: bound to mpc_regs at the foot
`timescale 1ns/1ps
module mpc_regs_monitor
  import mpc_pkg::*;
#(
  parameter mpc_cap_t SRC_CAP = '0,
  parameter mpc_cap_t DST_CAP = '0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic req_ready,
  input mpc_req_t  req,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input mpc_rsp_t  rsp,
  input wire logic fwd_in_valid,
  input wire logic fwd_in_ready,
  input mpc_pkt_t  fwd_in,
  input wire logic fwd_out_valid,
  input wire logic fwd_out_ready,
  input mpc_pkt_t  fwd_out,
  input wire logic busy
);
  // bit n of the field list sits at vector bit 31-n
  function automatic logic [31:0] capw(input mpc_cap_t c);
    return {14'h0, c.impl_a, 4'h0, c.data_msg, c.doorbell, 8'h0, c.impl_b};
  endfunction
  wire tk   = req_valid && req_ready;
  wire rd_w = tk && !req.write && !req.dword;
  wire fk   = fwd_in_valid && fwd_in_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_answer_next: assert property (tk |=> rsp_valid && busy)
    else $error("no response one cycle after request");
  a_rsp_holds: assert property (rsp_valid && !(rsp_ready && ce) |=> rsp_valid && $stable(rsp))
    else $error("response changed before consumed");
  a_rsp_release: assert property (rsp_valid && rsp_ready && ce |=> !rsp_valid ##1 req_ready || !ce)
    else $error("response not released");
  a_status_done: assert property (rsp_valid |-> rsp.status == STAT_DONE)
    else $error("error status returned");
  a_src_word: assert property (rd_w && req.offset[23:2] == 22'h6 |=> rsp.rdata == {32'h0, capw(SRC_CAP)})
    else $error("source capability word wrong");
  a_dst_word: assert property (rd_w && req.offset[23:2] == 22'h7 |=> rsp.rdata == {32'h0, capw(DST_CAP)})
    else $error("destination capability word wrong");
  a_rsvd_zero: assert property (rd_w && req.offset < 24'h010000 && req.offset[23:3] != 21'h3 |=> rsp.rdata == '0)
    else $error("reserved offset read nonzero");
  a_write_rsp: assert property (tk && req.write |=> rsp.write && rsp.rdata == '0)
    else $error("write response wrong");
  a_fwd_pass: assert property (fk |=> fwd_out_valid && fwd_out == $past(fwd_in))
    else $error("packet not passed unchanged");
  a_ce_stall: assert property (!ce |-> !req_ready && !fwd_in_ready)
    else $error("ready raised while clock enable low");
  c_src_read: cover property (rd_w && req.offset == OFS_SRC_CAP);
  c_write: cover property (tk && req.write);
  c_doorbell_fwd: cover property (fk && fwd_in.ftype == 4'hA);
endmodule
bind mpc_regs mpc_regs_monitor #(.SRC_CAP(SRC_CAP), .DST_CAP(DST_CAP)) mpc_regs_monitor_inst (
  .clk(clk), .rst(rst), .ce(ce), .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .fwd_in_valid(fwd_in_valid),
  .fwd_in_ready(fwd_in_ready), .fwd_in(fwd_in), .fwd_out_valid(fwd_out_valid),
  .fwd_out_ready(fwd_out_ready), .fwd_out(fwd_out), .busy(busy));

// *** mpc_requester.sv ***
// Purpose: remote element issuing maintenance accesses
// Assumes: drives on the falling edge
// Notes: released request lines carry inverted data
`timescale 1ns/1ps
module mpc_requester
  import mpc_pkg::*;
(
  input  wire logic clk,
  input  wire logic req_ready,
  input  wire logic rsp_valid,
  input  mpc_rsp_t  rsp,
  output logic      req_valid,
  output mpc_req_t  req,
  output logic      rsp_ready
);
  int       hold_cyc = 0;
  int       to_err   = 0;
  mpc_rsp_t last;
  initial
  begin
    req_valid = 1'b0;
    req       = '0;
    rsp_ready = 1'b0;
  end
  // one access outstanding; hold_cyc delays rsp_ready to take the response slowly
  task automatic op(input logic w, input logic d, input logic [23:0] o, input logic [63:0] wd);
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req       = '{w, d, o, wd};
    while (!req_ready)
      @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    req       = ~req;
    while (!rsp_valid && n < 20)
    begin
      n++;
      @(negedge clk);
    end
    to_err += int'(n == 20);
    repeat (hold_cyc)
      @(negedge clk);
    last      = rsp;
    rsp_ready = 1'b1;
    @(negedge clk);
    rsp_ready = 1'b0;
  endtask
  // read, merge defined bits only, write back the rest
  task automatic rmw(input logic [23:0] o, input logic [31:0] m, input logic [31:0] v);
    op(1'b0, 1'b0, o, 64'h0);
    op(1'b1, 1'b0, o, {32'h0, (last.rdata[31:0] & ~m) | (v & m)});
  endtask
endmodule

// *** mpc_regs_tb_top.sv ***
// Purpose: self-checking bench for the capability bank
// Assumes: inputs driven on the falling edge
// Notes: non-default capability settings catch swapped bits
`timescale 1ns/1ps
module mpc_regs_tb_top
  import mpc_pkg::*;
;
  localparam mpc_cap_t    SRC   = '{1'b1, 1'b0, 2'b10, 2'b01};
  localparam mpc_cap_t    DST   = '{1'b0, 1'b1, 2'b01, 2'b10};
  localparam logic [31:0] SRC_W = 32'h00020801;
  localparam logic [31:0] DST_W = 32'h00010402;
  localparam logic [63:0] CAP_MASK = 64'h0000000000030C03;
  logic        clk, rst, ce, req_valid, req_ready, rsp_valid, rsp_ready, busy;
  logic        fwd_in_valid, fwd_in_ready, fwd_out_valid, fwd_out_ready;
  mpc_req_t    req;
  mpc_rsp_t    rsp;
  mpc_rsp_t    got;
  mpc_pkt_t    fwd_in, fwd_out, p;
  int          mismatches = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  logic [23:0] rsv [8]    = '{24'h0, 24'h14, 24'h20, 24'h3C, 24'h40, 24'hFC, 24'h100, 24'hFFFC};
  assign got = mpc_requester_inst.last;
  mpc_regs #(.SRC_CAP(SRC), .DST_CAP(DST)) mpc_regs_inst (.clk(clk), .rst(rst), .ce(ce),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp(rsp), .fwd_in_valid(fwd_in_valid), .fwd_in_ready(fwd_in_ready),
    .fwd_in(fwd_in), .fwd_out_valid(fwd_out_valid), .fwd_out_ready(fwd_out_ready),
    .fwd_out(fwd_out), .busy(busy));
  mpc_requester mpc_requester_inst (.clk(clk), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .req_valid(req_valid), .req(req), .rsp_ready(rsp_ready));
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rd(input logic [23:0] o);
    mpc_requester_inst.op(1'b0, 1'b0, o, 64'h0);
  endtask
  initial
  begin
    clk = 1'b0;
    forever
      #25 clk = ~clk;
  end
  // cuts a hang short well past the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      end_sim();
    end
  end
  initial
  begin
    rst           = 1'b1;
    ce            = 1'b1;
    fwd_in_valid  = 1'b0;
    fwd_in        = '0;
    fwd_out_ready = 1'b1;
    repeat (12)
      @(negedge clk);
    rst = 1'b0;
    chk("busy_rst", {rsp_valid, busy}, 2'b00);
    rd(OFS_SRC_CAP);
    chk("src", got.rdata, {32'h0, SRC_W});
    rd(OFS_DST_CAP);
    chk("dst", got.rdata, {32'h0, DST_W});
    chk("dst_def", got.rdata & CAP_MASK, {32'h0, DST_W} & CAP_MASK);
    mpc_requester_inst.op(1'b1, 1'b0, OFS_SRC_CAP, '1);
    chk("wr_stat", got.status, STAT_DONE);
    rd(OFS_SRC_CAP);
    chk("src_ro", got.rdata, {32'h0, SRC_W});
    mpc_requester_inst.op(1'b0, 1'b1, OFS_SRC_CAP, 64'h0);
    chk("dword", got.rdata, {SRC_W, DST_W});
    mpc_requester_inst.hold_cyc = 3;
    foreach (rsv[i])
    begin
      mpc_requester_inst.op(1'b1, 1'b0, rsv[i], '1);
      chk("rsv_wst", got.status, STAT_DONE);
      rd(rsv[i]);
      chk("rsv_rd", got.rdata, 64'h0);
    end
    mpc_requester_inst.hold_cyc = 0;
    mpc_requester_inst.rmw(OFS_IMPL_SCRATCH, 32'h0000FFFF, 32'h1234ABCD);
    mpc_requester_inst.rmw(OFS_IMPL_SCRATCH, 32'hFFFF0000, 32'h5A5A0000);
    rd(OFS_IMPL_SCRATCH);
    chk("scratch", got.rdata, 64'h5A5AABCD);
    // every format type, back to back
    for (int t = 0; t < 16; t++)
    begin
      p            = '{t[3:0], t[0], 32'hC0DE0000 + t};
      fwd_in_valid = 1'b1;
      fwd_in       = p;
      @(negedge clk);
      chk("fwd", {fwd_out_valid, fwd_out}, {1'b1, p});
    end
    // last packet already taken: withdraw valid, then stall the output
    fwd_in_valid  = 1'b0;
    fwd_out_ready = 1'b0;
    @(negedge clk);
    chk("fwd_hold", {fwd_in_ready, fwd_out_valid, fwd_out}, {2'b01, p});
    ce            = 1'b0;
    fwd_out_ready = 1'b1;
    @(negedge clk);
    chk("ce_freeze", {req_ready, fwd_in_ready, fwd_out_valid, fwd_out}, {3'b001, p});
    ce = 1'b1;
    @(negedge clk);
    chk("fwd_drain", fwd_out_valid, 64'h0);
    rd(OFS_IMPL_RD_CNT);
    chk("rd_cnt", got.rdata, 64'h000000000000000F);
    rd(OFS_IMPL_WR_CNT);
    chk("wr_cnt", got.rdata, 64'h000000000000000B);
    rd(OFS_IMPL_FWD_CNT);
    chk("fwd_cnt", got.rdata, 64'h0000000000000010);
    mpc_requester_inst.op(1'b1, 1'b0, OFS_IMPL_WR_CNT, '1);
    rd(OFS_IMPL_WR_CNT);
    chk("wr_cnt_clr", got.rdata, 64'h0000000000000001);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk("busy_rst2", {rsp_valid, busy}, 2'b00);
    rd(OFS_IMPL_SCRATCH);
    chk("scratch_rst", got.rdata, 64'h0);
    rd(OFS_SRC_CAP);
    chk("src_rst", got.rdata, {32'h0, SRC_W});
    chk("timeouts", mpc_requester_inst.to_err, 0);
    end_sim();
  end
endmodule
